/* File: hdl/twc_master.sv */
/*
  Two-wire master: register port, command decode, status flags, bus
  state monitor and bit sequencer driving open-drain pins.
  Assumes a one-cycle register port on clk, bus pins resolved outside
  (oe high pulls the line low) and clk at least 4x the serial clock.
*/
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "twc_params.svh"
module twc_master (
  input  logic       clk,
  input  logic       nrst,
  input  logic [3:0] reg_addr,
  input  logic [7:0] reg_wdata,
  input  logic       reg_wr,
  input  logic       reg_rd,
  output logic [7:0] reg_rdata,
  input  logic       scl_in,
  output logic       scl_out,
  output logic       scl_oe,
  input  logic       sda_in,
  output logic       sda_out,
  output logic       sda_oe
);
  twc_pkg::twc_state_e state_reg;
  twc_pkg::twc_state_e state_last_reg;
  twc_pkg::twc_job_e   job_reg;
  twc_pkg::twc_next_e  nxt_reg;
  twc_pkg::twc_next_e  hold_nx;
  logic [8:0] cnt_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] sh_reg;
  logic [7:0] baud_reg;
  logic [7:0] addr_reg;
  logic [7:0] rdata_reg;
  logic [1:0] bus_reg;
  logic [1:0] cmd;
  logic en_reg, acknowledge_action_reg, lost_reg, last_rx_reg, is_addr_reg;
  logic rif_reg, wif_reg, hold_reg, received_ack_bit_reg, arb_reg, berr_reg;
  logic scl_oe_reg, sda_oe_reg, pin_low_reg;
  logic [1:0] pin_want;
  logic scl_meta_reg, scl_s_reg, scl_d_reg;
  logic sda_meta_reg, sda_s_reg, sda_d_reg;
  logic wr_ctrl1, wr_ctrl2, wr_stat, wr_baud, wr_addr, wr_data, rd_data;
  logic cmd_go, go_addr, start_det, stop_det, stall, tick, end_bit;
  logic last_bit, drv1, arb_hit, lost_now, auto_rx, done_tx, done_rx;
  logic done_ack, sr_lost, start_unk, bus_err_ev, clr_if, clr_addr;
  logic hold_go, hold_tx, hold_ack;
  logic set_rif, set_wif, set_hold, set_arb, set_berr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  function automatic logic hit(input logic stb, input logic [3:0] a,
                               input logic [3:0] off);
    return stb && (a == off);
  endfunction

  // ==========================================================
  // Register port decode
  assign wr_ctrl1 = hit(reg_wr, reg_addr, `TWC_OFF_CTRL1);
  assign wr_ctrl2 = hit(reg_wr, reg_addr, `TWC_OFF_CTRL2);
  assign wr_stat  = hit(reg_wr, reg_addr, `TWC_OFF_STAT);
  assign wr_baud  = hit(reg_wr, reg_addr, `TWC_OFF_BAUD);
  assign wr_addr  = hit(reg_wr, reg_addr, `TWC_OFF_ADDR);
  assign wr_data  = hit(reg_wr, reg_addr, `TWC_OFF_DATA);
  assign rd_data  = hit(reg_rd, reg_addr, `TWC_OFF_DATA);
  assign cmd      = reg_wdata[1:0];
  assign cmd_go   = wr_ctrl2 && (cmd != `TWC_CMD_NONE);
  assign go_addr  = wr_addr && en_reg;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      en_reg     <= 1'b0;
      acknowledge_action_reg <= 1'b0;
      baud_reg   <= `TWC_RST_BYTE;
      addr_reg   <= `TWC_RST_BYTE;
    end else begin
      if (wr_ctrl1)
        en_reg <= reg_wdata[`TWC_BIT_EN];
      if (wr_ctrl2)
        acknowledge_action_reg <= reg_wdata[`TWC_BIT_ACKNOWLEDGE_ACTION];
      if (wr_baud)
        baud_reg <= reg_wdata;
      if (wr_addr)
        addr_reg <= reg_wdata;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!nrst || !reg_rd) begin
      rdata_reg <= `TWC_RST_BYTE;
    end else begin
      unique case (reg_addr)
        `TWC_OFF_CTRL1: rdata_reg <= {7'h00, en_reg};
        `TWC_OFF_CTRL2: rdata_reg <= {5'h00, acknowledge_action_reg, `TWC_CMD_NONE};
        `TWC_OFF_STAT:  rdata_reg <= {rif_reg, wif_reg, hold_reg,
                                      received_ack_bit_reg, arb_reg, berr_reg,
                                      bus_reg};
        `TWC_OFF_BAUD:  rdata_reg <= baud_reg;
        `TWC_OFF_ADDR:  rdata_reg <= addr_reg;
        `TWC_OFF_DATA:  rdata_reg <= sh_reg;
        default:        rdata_reg <= `TWC_RST_BYTE;
      endcase
    end
  end

  // ==========================================================
  // Pin synchronisers and bus condition detectors
  always_ff @(posedge clk) begin
    if (!nrst) begin
      {scl_meta_reg, scl_s_reg, scl_d_reg} <= 3'h7;
      {sda_meta_reg, sda_s_reg, sda_d_reg} <= 3'h7;
    end else begin
      {scl_meta_reg, scl_s_reg, scl_d_reg} <= {scl_in, scl_meta_reg,
                                               scl_s_reg};
      {sda_meta_reg, sda_s_reg, sda_d_reg} <= {sda_in, sda_meta_reg,
                                               sda_s_reg};
    end
  end

  assign start_det = scl_s_reg && scl_d_reg && sda_d_reg && !sda_s_reg;
  assign stop_det  = scl_s_reg && scl_d_reg && !sda_d_reg && sda_s_reg;

  // ==========================================================
  // Phase timer, stretched while the clock line is held low
  assign stall = (state_reg == twc_pkg::ST_BIT_HIGH ||
                  state_reg == twc_pkg::ST_SR_HIGH ||
                  state_reg == twc_pkg::ST_P_HIGH) && !scl_s_reg;
  assign tick = (state_reg == state_last_reg) &&
                (cnt_reg == {1'b0, baud_reg} + `TWC_BAUD_ADD);

  always_ff @(posedge clk) begin
    if (!nrst)
      state_last_reg <= twc_pkg::ST_IDLE;
    else
      state_last_reg <= state_reg;
    if (!nrst || tick || state_reg != state_last_reg)
      cnt_reg <= '0;
    else if (!stall)
      cnt_reg <= cnt_reg + 9'h001;
  end

  // ==========================================================
  // Bit events
  always_comb begin
    unique case (job_reg)
      twc_pkg::JB_TX:  drv1 = lost_reg || bit_cnt_reg == `TWC_LAST_BIT ||
                              sh_reg[7];
      twc_pkg::JB_RX:  drv1 = 1'b1;
      twc_pkg::JB_ACK: drv1 = lost_reg || acknowledge_action_reg;
      default:         drv1 = 1'b1;
    endcase
  end

  assign end_bit  = (state_reg == twc_pkg::ST_BIT_HIGH) && tick;
  assign last_bit = end_bit && (bit_cnt_reg == `TWC_LAST_BIT);
  assign arb_hit  = end_bit && drv1 && !sda_s_reg &&
                    (job_reg == twc_pkg::JB_ACK ||
                     (job_reg == twc_pkg::JB_TX &&
                      bit_cnt_reg != `TWC_LAST_BIT));
  assign lost_now = lost_reg || arb_hit;
  assign auto_rx  = is_addr_reg && addr_reg[0] && !sda_s_reg;
  assign done_tx  = last_bit && job_reg == twc_pkg::JB_TX;
  assign done_rx  = last_bit && job_reg == twc_pkg::JB_RX;
  assign done_ack = last_bit && job_reg == twc_pkg::JB_ACK;
  assign sr_lost  = (state_reg == twc_pkg::ST_SR_HIGH) && tick &&
                    !sda_s_reg;
  assign start_unk = go_addr && state_reg == twc_pkg::ST_IDLE &&
                     bus_reg == `TWC_BS_UNKNOWN;
  assign bus_err_ev = en_reg && (start_det || stop_det) &&
                      (state_reg == twc_pkg::ST_BIT_LOW ||
                       state_reg == twc_pkg::ST_BIT_HIGH);

  // What a software access asks of a held bus
  always_comb begin
    hold_go = 1'b1;
    hold_tx = 1'b0;
    hold_nx = twc_pkg::NX_NONE;
    if (go_addr)
      hold_nx = twc_pkg::NX_SR;
    else if (cmd_go && cmd == `TWC_CMD_SR)
      hold_nx = twc_pkg::NX_SR;
    else if (cmd_go && cmd == `TWC_CMD_XFER && addr_reg[0])
      hold_nx = twc_pkg::NX_RX;
    else if (cmd_go && cmd == `TWC_CMD_XFER)
      hold_tx = 1'b1;
    else if (cmd_go)
      hold_nx = twc_pkg::NX_STOP;
    else if (wr_data)
      hold_tx = 1'b1;
    else if (rd_data && last_rx_reg)
      hold_nx = twc_pkg::NX_RX;
    else
      hold_go = 1'b0;
  end
  assign hold_ack = hold_go && !hold_tx &&
                    (last_rx_reg || hold_nx == twc_pkg::NX_RX);

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk) begin
    if (!nrst || !en_reg) begin
      state_reg   <= twc_pkg::ST_IDLE;
      job_reg     <= twc_pkg::JB_TX;
      nxt_reg     <= twc_pkg::NX_NONE;
      bit_cnt_reg <= '0;
      sh_reg      <= `TWC_RST_BYTE;
      lost_reg    <= 1'b0;
      last_rx_reg <= 1'b0;
      is_addr_reg <= 1'b0;
    end else if (bus_err_ev || sr_lost) begin
      state_reg <= twc_pkg::ST_IDLE;
    end else begin
      unique case (state_reg)
        twc_pkg::ST_IDLE: begin
          if (go_addr && bus_reg == `TWC_BS_IDLE)
            state_reg <= twc_pkg::ST_START;
          else if (go_addr && bus_reg != `TWC_BS_UNKNOWN)
            state_reg <= twc_pkg::ST_WAIT;
        end
        twc_pkg::ST_WAIT: begin
          if (bus_reg == `TWC_BS_IDLE)
            state_reg <= twc_pkg::ST_START;
        end
        twc_pkg::ST_START: begin
          if (tick) begin
            state_reg   <= twc_pkg::ST_BIT_LOW;
            job_reg     <= twc_pkg::JB_TX;
            bit_cnt_reg <= `TWC_TX_BITS;
            sh_reg      <= addr_reg;
            lost_reg    <= 1'b0;
            is_addr_reg <= 1'b1;
            last_rx_reg <= 1'b0;
          end
        end
        twc_pkg::ST_SR_LOW: begin
          if (tick)
            state_reg <= twc_pkg::ST_SR_HIGH;
        end
        twc_pkg::ST_SR_HIGH: begin
          if (tick)
            state_reg <= twc_pkg::ST_START;
        end
        twc_pkg::ST_BIT_LOW: begin
          if (tick)
            state_reg <= twc_pkg::ST_BIT_HIGH;
        end
        twc_pkg::ST_BIT_HIGH: begin
          if (tick) begin
            bit_cnt_reg <= bit_cnt_reg - 4'h1;
            lost_reg    <= lost_now;
            if (job_reg == twc_pkg::JB_RX)
              sh_reg <= {sh_reg[6:0], sda_s_reg};
            else if (job_reg == twc_pkg::JB_TX && !last_bit)
              sh_reg <= {sh_reg[6:0], 1'b1};
            if (!last_bit) begin
              state_reg <= twc_pkg::ST_BIT_LOW;
            end else if (job_reg == twc_pkg::JB_RX) begin
              state_reg   <= twc_pkg::ST_HOLD;
              last_rx_reg <= 1'b1;
            end else if (lost_now) begin
              state_reg <= twc_pkg::ST_IDLE;
            end else if (job_reg == twc_pkg::JB_TX && auto_rx) begin
              state_reg   <= twc_pkg::ST_BIT_LOW;
              job_reg     <= twc_pkg::JB_RX;
              bit_cnt_reg <= `TWC_RX_BITS;
              is_addr_reg <= 1'b0;
            end else if (job_reg == twc_pkg::JB_TX ||
                         nxt_reg == twc_pkg::NX_NONE) begin
              state_reg   <= twc_pkg::ST_HOLD;
              is_addr_reg <= 1'b0;
              last_rx_reg <= 1'b0;
            end else if (nxt_reg == twc_pkg::NX_RX) begin
              state_reg   <= twc_pkg::ST_BIT_LOW;
              job_reg     <= twc_pkg::JB_RX;
              bit_cnt_reg <= `TWC_RX_BITS;
            end else if (nxt_reg == twc_pkg::NX_SR) begin
              state_reg <= twc_pkg::ST_SR_LOW;
            end else begin
              state_reg <= twc_pkg::ST_P_LOW;
            end
          end
        end
        twc_pkg::ST_HOLD: begin
          if (hold_tx) begin
            state_reg   <= twc_pkg::ST_BIT_LOW;
            job_reg     <= twc_pkg::JB_TX;
            bit_cnt_reg <= `TWC_TX_BITS;
            last_rx_reg <= 1'b0;
            if (wr_data)
              sh_reg <= reg_wdata;
          end else if (hold_ack) begin
            state_reg   <= twc_pkg::ST_BIT_LOW;
            job_reg     <= twc_pkg::JB_ACK;
            bit_cnt_reg <= `TWC_ACK_BITS;
            nxt_reg     <= hold_nx;
          end else if (hold_nx == twc_pkg::NX_SR) begin
            state_reg <= twc_pkg::ST_SR_LOW;
          end else if (hold_nx == twc_pkg::NX_STOP) begin
            state_reg <= twc_pkg::ST_P_LOW;
          end
        end
        twc_pkg::ST_P_LOW: begin
          if (tick)
            state_reg <= twc_pkg::ST_P_HIGH;
        end
        twc_pkg::ST_P_HIGH: begin
          if (tick)
            state_reg <= twc_pkg::ST_P_REL;
        end
        twc_pkg::ST_P_REL: begin
          if (tick)
            state_reg <= twc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Pin drive: oe high pulls the line low
  always_comb begin
    unique case (state_reg)
      twc_pkg::ST_START:    pin_want = 2'h1;
      twc_pkg::ST_SR_LOW,
      twc_pkg::ST_HOLD:     pin_want = 2'h2;
      twc_pkg::ST_BIT_LOW:  pin_want = {1'b1, !drv1};
      twc_pkg::ST_BIT_HIGH: pin_want = {1'b0, !drv1};
      twc_pkg::ST_P_LOW:    pin_want = 2'h3;
      twc_pkg::ST_P_HIGH:   pin_want = 2'h1;
      default:              pin_want = 2'h0;
    endcase
  end

  // Data line moves a cycle after the clock line falls
  always_ff @(posedge clk) begin
    pin_low_reg <= 1'b0;
    if (!nrst)
      {scl_oe_reg, sda_oe_reg} <= 2'h0;
    else if (pin_want[1] && !scl_oe_reg)
      scl_oe_reg <= 1'b1;
    else
      {scl_oe_reg, sda_oe_reg} <= pin_want;
  end

  // ==========================================================
  // Status flags; a hardware set wins over any clear
  assign clr_addr = wr_addr;
  assign clr_if   = wr_data || rd_data || cmd_go || wr_addr;
  assign set_rif  = done_rx && !lost_reg && !bus_err_ev;
  assign set_wif  = (done_tx && (lost_now || !auto_rx)) ||
                    (done_ack && lost_now) || sr_lost || start_unk ||
                    bus_err_ev;
  assign set_hold = (done_tx && !lost_now && !auto_rx) || done_rx;
  assign set_arb  = arb_hit || sr_lost;
  assign set_berr = bus_err_ev || start_unk;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      {rif_reg, wif_reg, hold_reg} <= 3'h0;
      {received_ack_bit_reg, arb_reg, berr_reg} <= 3'h0;
    end else begin
      rif_reg  <= set_rif || (rif_reg && !clr_if && !set_wif &&
                  !(wr_stat && reg_wdata[`TWC_BIT_RIF]));
      wif_reg  <= (set_wif && !set_rif) || (wif_reg && !clr_if &&
                  !set_rif && !(wr_stat && reg_wdata[`TWC_BIT_WIF]));
      hold_reg <= set_hold || (hold_reg && !clr_if &&
                  state_reg == twc_pkg::ST_HOLD &&
                  !(wr_stat && reg_wdata[`TWC_BIT_HOLD]));
      arb_reg  <= set_arb || (arb_reg && !clr_addr &&
                  !(wr_stat && reg_wdata[`TWC_BIT_ARB]));
      berr_reg <= set_berr || (berr_reg && !clr_addr &&
                  !(wr_stat && reg_wdata[`TWC_BIT_BERR]));
      if (done_tx)
        received_ack_bit_reg <= sda_s_reg;
    end
  end

  // ==========================================================
  // Bus state monitor
  always_ff @(posedge clk) begin
    if (!nrst || !en_reg)
      bus_reg <= `TWC_BS_UNKNOWN;
    else if (wr_stat && reg_wdata[1:0] == `TWC_BS_IDLE)
      bus_reg <= `TWC_BS_IDLE;
    else if (set_arb)
      bus_reg <= `TWC_BS_BUSY;
    else if (stop_det)
      bus_reg <= `TWC_BS_IDLE;
    else if (start_det)
      bus_reg <= (state_reg == twc_pkg::ST_START) ? `TWC_BS_OWNER
                                                   : `TWC_BS_BUSY;
  end

  assign reg_rdata = rdata_reg;
  assign scl_oe    = scl_oe_reg;
  assign sda_oe    = sda_oe_reg;
  assign scl_out   = pin_low_reg;
  assign sda_out   = pin_low_reg;

  // ==========================================================
  // Checks
  sequence s_tx_end;
    last_bit && job_reg == twc_pkg::JB_TX && (lost_now || !auto_rx);
  endsequence
  sequence s_addr_go;
    go_addr && state_reg == twc_pkg::ST_IDLE && bus_reg == `TWC_BS_IDLE
      && !bus_err_ev;
  endsequence

  a_cmd_reads_zero: assert property (reg_rd && reg_addr == `TWC_OFF_CTRL2
    |=> reg_rdata[1:0] == `TWC_CMD_NONE)
    else $error("command bits read nonzero");
  a_ack_same_write: assert property (cmd_go &&
    state_reg == twc_pkg::ST_HOLD && hold_ack && !bus_err_ev
    |=> state_reg == twc_pkg::ST_BIT_LOW && job_reg == twc_pkg::JB_ACK
        && drv1 == $past(reg_wdata[`TWC_BIT_ACKNOWLEDGE_ACTION]))
    else $error("ack action not taken from same write");
  a_rif_clean: assert property ($rose(rif_reg)
    |-> $past(job_reg == twc_pkg::JB_RX && !lost_reg))
    else $error("read flag without clean read");
  a_wif_on_send: assert property (s_tx_end |=> wif_reg)
    else $error("write flag missing after send");
  a_rif_w1c: assert property (wr_stat && reg_wdata[`TWC_BIT_RIF] &&
    !set_rif |=> !rif_reg)
    else $error("read flag not cleared by one");
  a_hold_pins: assert property (hold_reg && $past(hold_reg)
    |-> scl_oe_reg)
    else $error("hold flag without clock held low");
  a_addr_clears: assert property (wr_addr && !set_arb && !set_berr
    |=> !arb_reg && !berr_reg)
    else $error("address write left error flags");
  a_berr_set: assert property (bus_err_ev |=> berr_reg ##1
    state_reg == twc_pkg::ST_IDLE)
    else $error("bus error not flagged");
  a_force_idle: assert property (en_reg && wr_stat &&
    reg_wdata[1:0] == `TWC_BS_IDLE |=> bus_reg == `TWC_BS_IDLE)
    else $error("bus state not forced idle");
  a_bus_unknown: assert property (!en_reg
    |=> bus_reg == `TWC_BS_UNKNOWN)
    else $error("bus state known while disabled");
  a_addr_start: assert property (s_addr_go
    |=> state_reg == twc_pkg::ST_START ##1 sda_oe_reg && !scl_oe_reg)
    else $error("no start after address write");
  a_no_action_code_quiet: assert property (wr_ctrl2 && cmd == `TWC_CMD_NONE
    && state_reg == twc_pkg::ST_HOLD && hold_reg
    |=> state_reg == twc_pkg::ST_HOLD && hold_reg)
    else $error("no-action command disturbed the master");
  a_flags_excl: assert property (!(rif_reg && wif_reg))
    else $error("both completion flags set");
endmodule

/* File: inc/twc_params.svh */
/*
  Register offsets, field positions, codes and counts of the
  two-wire master. Definitions only; included by the design file.
*/
`ifndef TWC_PARAMS_SVH
`define TWC_PARAMS_SVH
`define TWC_OFF_CTRL1  4'h3
`define TWC_OFF_CTRL2  4'h4
`define TWC_OFF_STAT   4'h5
`define TWC_OFF_BAUD   4'h6
`define TWC_OFF_ADDR   4'h7
`define TWC_OFF_DATA   4'h8
`define TWC_BIT_EN     0
`define TWC_BIT_ACKNOWLEDGE_ACTION 2
`define TWC_BIT_RIF    7
`define TWC_BIT_WIF    6
`define TWC_BIT_HOLD   5
`define TWC_BIT_ARB    3
`define TWC_BIT_BERR   2
`define TWC_CMD_NONE   2'h0
`define TWC_CMD_SR     2'h1
`define TWC_CMD_XFER   2'h2
`define TWC_CMD_STOP   2'h3
`define TWC_BS_UNKNOWN 2'h0
`define TWC_BS_IDLE    2'h1
`define TWC_BS_OWNER   2'h2
`define TWC_BS_BUSY    2'h3
`define TWC_RST_BYTE   8'h00
`define TWC_BAUD_ADD   9'h005
`define TWC_TX_BITS    4'h9
`define TWC_RX_BITS    4'h8
`define TWC_ACK_BITS   4'h1
`define TWC_LAST_BIT   4'h1
`endif

/* File: inc/twc_pkg.sv */
/*
  Types of the two-wire master: sequencer states, the kind of bit
  job in flight and what follows an acknowledge bit.
  Assumes nothing of its surroundings.
*/
package twc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_WAIT, ST_START, ST_SR_LOW, ST_SR_HIGH, ST_BIT_LOW,
    ST_BIT_HIGH, ST_HOLD, ST_P_LOW, ST_P_HIGH, ST_P_REL
  } twc_state_e;
  typedef enum logic [1:0] {JB_TX, JB_RX, JB_ACK} twc_job_e;
  typedef enum logic [1:0] {NX_NONE, NX_RX, NX_SR, NX_STOP} twc_next_e;
endpackage

/* File: dv/twc_slave_model.sv */
/* Behavioural two-wire slave: acks every address and written byte,
   returns rd_byte on reads, stops sending after a nack.
   Assumes resolved, pulled-up scl and sda wires. */
`timescale 1ns/1ps
module twc_slave_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] rd_byte,
  output logic            pull,
  output logic [7:0]      got
);
  int         cnt = 0;
  logic       first = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] sh = 8'h00;
  initial pull = 1'b0;
  initial got = 8'h00;
  // ==========================================
  // Start, repeated start and stop
  always @(negedge sda) if (scl) begin
    cnt = 0;
    first = 1'b1;
  end
  always @(posedge sda) if (scl) cnt = 0;
  // ==========================================
  // Bit capture on rising clock
  always @(posedge scl) begin
    if (cnt < 8) sh = {sh[6:0], sda};
    if (cnt == 7 && first) rd = sda;
    if (cnt == 8) got = sh;
    if (cnt == 8 && sda) rd = 1'b0;
    cnt = cnt + 1;
  end
  // Drive ack or data while the clock is low
  always @(negedge scl) begin
    if (cnt == 9) cnt = 0;
    if (cnt == 9 || cnt == 0) first = first && cnt != 0 ? first : first;
    if (cnt == 8) pull = first || !rd;
    else pull = rd && !first && !rd_byte[7 - cnt];
    if (cnt == 8) first = 1'b0;
  end
endmodule

/* File: dv/twc_master_tb_top.sv */
/* Bench for the two-wire master: register tasks, slave model on the
   wires and one task per scenario. Assumes a 40 MHz clk. */
`timescale 1ns/1ps
module twc_master_tb_top;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata, got, v;
  logic       scl_out, scl_oe, sda_out, sda_oe, pull;
  wire        scl = ~scl_oe;
  logic       jam = 1'b0;
  wire        sda = ~(sda_oe | pull | jam);
  int         failures = 0;
  int         n_checks = 0;
  always #12.5 clk = ~clk;
  twc_master uut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scl_in(scl), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
  twc_slave_model slave (.scl(scl), .sda(sda), .rd_byte(8'hC3),
    .pull(pull), .got(got));
  // ==========================================
  // Register port and checking
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task poll(input logic [7:0] m, input logic [7:0] e);
    int i;
    v = 8'h00;
    for (i = 0; i < 400 && (v & m) !== (e & m); i++) rd(4'h5, v);
    chk(v, e);
  endtask
  // ==========================================
  // Scenarios
  task t_reset;
    rd(4'h5, v); chk(v, 8'h00);
    rd(4'h6, v); chk(v, 8'h00);
    rd(4'h7, v); chk(v, 8'h00);
    chk({6'h00, scl_out, sda_out}, 8'h00);
    $display("reset test done");
  endtask
  task t_unknown;
    wr(4'h3, 8'h01);
    wr(4'h7, 8'hA4);
    rd(4'h5, v); chk(v, 8'h44);
    wr(4'h5, 8'h01);
    rd(4'h5, v); chk(v, 8'h45);
    wr(4'h5, 8'hC4);
    rd(4'h5, v); chk(v, 8'h01);
    $display("unknown bus test done");
  endtask
  task t_write;
    wr(4'h7, 8'hA4);
    poll(8'h40, 8'h62);
    chk({7'h00, scl_oe}, 8'h01);
    chk(got, 8'hA4);
    wr(4'h8, 8'h5A);
    rd(4'h5, v); chk(v, 8'h02);
    poll(8'h40, 8'h62);
    chk(got, 8'h5A);
    wr(4'h4, 8'h00);
    rd(4'h5, v); chk(v, 8'h62);
    wr(4'h4, 8'h02);
    rd(4'h5, v); chk(v, 8'h02);
    poll(8'h40, 8'h62);
    wr(4'h4, 8'h07);
    rd(4'h4, v); chk(v, 8'h04);
    poll(8'h03, 8'h01);
    $display("write test done");
  endtask
  task t_read;
    wr(4'h4, 8'h00);
    wr(4'h7, 8'hA5);
    poll(8'h80, 8'hA2);
    rd(4'h8, v); chk(v, 8'hC3);
    poll(8'h80, 8'hA2);
    wr(4'h4, 8'h05);
    rd(4'h5, v); chk(v, 8'h02);
    poll(8'h80, 8'hA2);
    wr(4'h4, 8'h07);
    poll(8'h03, 8'h01);
    $display("read test done");
  endtask
  task t_error;
    wr(4'h7, 8'hA4);
    wait (scl_oe === 1'b1);
    wait (scl === 1'b1);
    @(posedge clk);
    jam <= 1'b1;
    repeat (4) @(posedge clk);
    jam <= 1'b0;
    repeat (6) @(posedge clk);
    chk({6'h00, scl_oe, sda_oe}, 8'h00);
    rd(4'h5, v); chk(v, 8'h45);
    wr(4'h7, 8'hA4);
    rd(4'h5, v); chk(v, 8'h01);
    poll(8'h40, 8'h62);
    wr(4'h4, 8'h03);
    poll(8'h03, 8'h01);
    $display("bus error test done");
  endtask
  // ==========================================
  // Sequence, watchdog and verdict
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_unknown;
    t_write;
    t_read;
    t_error;
    wrap_up;
  end
  initial begin
    #1000000;
    failures++;
    wrap_up;
  end
endmodule
